// ### sim/tb_vrs_seq.sv
// Self-checking bench for the vertical region sequencer.
// Assumes the package, design and gate model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_vrs_seq;
  // Clock, reset and pins, driven 1 ns after rising edges
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic LINE_SYNC = 1'b0;
  logic FRAME_SYNC = 1'b0;
  logic PAT_WE = 1'b0;
  logic [1:0] PAT_ADDR = 2'h0;
  vrs_pkg::vrs_cfg_s CFG = '0;
  vrs_pkg::vrs_pat_s PAT_WDATA = '0;
  // Design outputs
  logic [3:0] VERT_OUT;
  logic [2:0] ACTIVE_REGION;
  logic SWEEP_ACTIVE;
  logic [7:0] LINE_COUNT;
  logic GROUP_BUSY;
  // Bench state
  int rise_cnt;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  vrs_pkg::vrs_pat_s pat [4];

  always #4 CLK = ~CLK;

  vrs_seq uut (.CLK(CLK), .RST(RST), .LINE_SYNC(LINE_SYNC),
    .FRAME_SYNC(FRAME_SYNC), .CFG(CFG), .PAT_WE(PAT_WE),
    .PAT_ADDR(PAT_ADDR), .PAT_WDATA(PAT_WDATA), .VERT_OUT(VERT_OUT),
    .ACTIVE_REGION(ACTIVE_REGION), .SWEEP_ACTIVE(SWEEP_ACTIVE),
    .LINE_COUNT(LINE_COUNT), .GROUP_BUSY(GROUP_BUSY));

  vrs_gate_model gate (.clk(CLK), .vout(VERT_OUT), .rises(rise_cnt));

  // Verdict and end of run
  task end_of_test;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Hang guard, well above the longest sweep
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      end_of_test();
    end
  end

  // One comparison, four-state exact
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // Settle past the edge before driving or sampling
  task step;
    @(posedge CLK);
    #1;
  endtask

  // Region model: highest change line not above the line
  function automatic int region(input int ln);
    int r;
    r = 0;
    for (int n = 1; n <= 4; n++) begin
      if (CFG.region_change_line[n-1] <= ln) begin
        r = n;
      end
    end
    return r;
  endfunction

  // Pattern model: pointer, then even or odd, then selector
  function automatic int pat_of(input int ln);
    int ptr;
    int s;
    ptr = CFG.region_pattern_pointer[region(ln)];
    s = (ptr < 4) ? ptr : 2 * (ptr - 4) + (ln % 2);
    return CFG.pattern_selector[s];
  endfunction

  // Line edge, with frame edge when asked; held two cycles
  task automatic pulse(input bit fr);
    step();
    LINE_SYNC = 1'b1;
    FRAME_SYNC = fr;
    step();
    step();
    LINE_SYNC = 1'b0;
    FRAME_SYNC = 1'b0;
  endtask

  // Status in force for a line
  task automatic stat(input int ln, input bit sw);
    chk("active_region", region(ln), ACTIVE_REGION);
    chk("line_count", ln, LINE_COUNT);
    chk("sweep_active", sw, SWEEP_ACTIVE);
  endtask

  // Follow n groups cycle by cycle against the pattern model
  task automatic run_grp(input int n, input int p, input int ln,
                         input bit sw, input bit mid);
    int k;
    int v;
    int rs;
    int s1;
    logic [3:0] e;
    logic [3:0] pe;
    k = 0;
    rs = 0;
    s1 = 0;
    pe = '0;
    while (GROUP_BUSY !== 1'b1 && k < 12) begin
      step();
      k++;
    end
    stat(ln, sw);
    // Extra line edge inside a sweep must not cut it short
    if (mid) begin
      fork
        pulse(1'b0);
      join_none
    end
    k = 0;
    while (GROUP_BUSY === 1'b1 && k < 20000) begin
      v = k % (pat[p].group_length + 1);
      for (int i = 0; i < 4; i++) begin
        e[i] = pat[p].start_level[i] ^ (pat[p].toggle_pos_1[i] < v)
          ^ (pat[p].toggle_pos_2[i] < v);
      end
      chk("vert_out", e, VERT_OUT);
      if (k == 1) begin
        s1 = rise_cnt;
      end
      if (k > 0 && e[0] && !pe[0]) begin
        rs++;
      end
      pe = e;
      step();
      k++;
    end
    chk("busy_cycles", n * (pat[p].group_length + 1), k);
    if (k > 1) begin
      chk("gate_rises", rs, rise_cnt - s1);
    end
  endtask

  initial begin
    int c;
    int p;
    int cnt;
    bit sw;
    void'($urandom(32'hF657));
    repeat (8) @(posedge CLK);
    #1;
    RST = 1'b0;
    chk("reset_state", 17'h0, {VERT_OUT, ACTIVE_REGION, SWEEP_ACTIVE,
      LINE_COUNT, GROUP_BUSY});
    $display("reset test done");
    // Random patterns, distinct toggles inside each group
    for (int q = 0; q < 4; q++) begin
      pat[q].group_length = 9'(5 + q);
      pat[q].start_level = 4'($urandom);
      for (int i = 0; i < 4; i++) begin
        pat[q].toggle_pos_1[i] = 9'($urandom % 2);
        pat[q].toggle_pos_2[i] = 9'(2 + $urandom % 3);
      end
      step();
      PAT_WE = 1'b1;
      PAT_ADDR = 2'(q);
      PAT_WDATA = pat[q];
    end
    step();
    PAT_WE = 1'b0;
    for (int f = 0; f < 6; f++) begin
      c = 0;
      CFG.sweep_mode_select = 2'h0;
      for (int i = 0; i < 5; i++) begin
        CFG.region_pattern_pointer[i] = 3'((i + f) % 6);
      end
      for (int i = 0; i < 4; i++) begin
        CFG.pattern_selector[i] = 2'(i + f);
        CFG.pattern_repeat_count[i] = 3'($urandom % 8);
        c = c + 1 + $urandom % 2;
        CFG.region_change_line[i] = 8'(c);
      end
      for (int ln = 0; ln < 10; ln++) begin
        pulse(ln == 0);
        p = pat_of(ln);
        run_grp(CFG.pattern_repeat_count[p], p, ln, 1'b0, 1'b0);
      end
    end
    $display("normal frame test done");
    // every sweep mode in regions 0, 1 and 3
    for (int m = 0; m < 4; m++) begin
      for (int r = 0; r < 4; r += (r == 1) ? 2 : 1) begin
        CFG.sweep_mode_select = 2'(m);
        CFG.region0_sweep_count = (m == 3 && r == 0) ? 12'hFFF : 12'h005;
        CFG.region3_sweep_count = 12'(3 + m);
        for (int n = 0; n < 4; n++) begin
          CFG.region_change_line[n] = (n < r) ? 8'h00 : 8'(2 + n);
        end
        sw = (r == 0 && m % 2 == 1) || (r == 3 && m / 2 == 1);
        p = pat_of(0);
        cnt = CFG.pattern_repeat_count[p];
        if (sw) begin
          cnt = (r == 0) ? CFG.region0_sweep_count : CFG.region3_sweep_count;
          cnt = (cnt > 2048) ? 2048 : cnt;
        end
        pulse(1'b1);
        run_grp(cnt, p, 0, sw, sw);
      end
    end
    $display("sweep test done");
    end_of_test();
  end
endmodule
`default_nettype wire

// ### sim/vrs_gate_model.sv
// Load model of the sensor's vertical transfer gates.
// Assumes the four phases arrive registered on the pixel clock.
`timescale 1ns/1ps
`default_nettype none
module vrs_gate_model (
  // Clock
  input wire logic clk,
  // Vertical phases from the sequencer
  input wire logic [3:0] vout,
  // Charge packets moved on phase 1
  output int rises
);
  // Last phase 1 level; a gate only moves charge on a rising phase
  logic prev = 1'b0;
  // Running transfer count, one process drives it
  int cnt_q = 0;

  assign rises = cnt_q;

  // Count phase 1 rising edges as transfers
  always @(posedge clk) begin
    prev <= vout[0];
    if (vout[0] === 1'b1 && prev === 1'b0) begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule
`default_nettype wire

// ### src/vrs_pat_mem.sv
// Small table holding the four transfer patterns.
// Assumes one writer and one reader, both on the pixel clock.
`timescale 1ns/1ps
`default_nettype none
module vrs_pat_mem #(
  parameter int WIDTH = 85,
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Write side
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // Read side, data one cycle after the address
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  // Storage needs no reset: software loads it before use
  logic [WIDTH-1:0] mem [DEPTH];

  // Write port
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read keeps the table off the output timing path
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule
`default_nettype wire

// ### src/vrs_pkg.sv
// Shared types and constants for the vertical region sequencer.
// Assumes a single pixel-rate clock and configuration held elsewhere.
`default_nettype none
package vrs_pkg;

  // Counts of regions, patterns, selectors and vertical outputs
  localparam int NUM_REGIONS = 5;
  localparam int NUM_PATTERNS = 4;
  localparam int NUM_SELECTORS = 4;
  localparam int NUM_VOUT = 4;
  localparam int NUM_CHANGES = 4;

  // Field widths
  localparam int PTR_W = 3;
  localparam int SEL_W = 2;
  localparam int REP_W = 3;
  localparam int LINE_W = 8;
  localparam int VCNT_W = 9;
  localparam int SWEEP_W = 12;

  // Control address of the sweep mode field
  localparam logic [7:0] SWEEP_CTRL_ADDR = 8'h0A;
  // Sweep mode field bits, one per sweep-capable region
  localparam int SWEEP_BIT_R0 = 0;
  localparam int SWEEP_BIT_R3 = 1;
  // Regions in which sweep may run
  localparam logic [2:0] SWEEP_REGION_A = 3'h0;
  localparam logic [2:0] SWEEP_REGION_B = 3'h3;
  // Largest number of sweep repeats in one region
  localparam logic [11:0] SWEEP_MAX_REPEATS = 12'h800;

  // Pointer codes that alternate selectors on even and odd lines
  localparam logic [2:0] PTR_ALT_LOW = 3'h4;
  localparam logic [2:0] PTR_ALT_HIGH = 3'h5;

  // Reset values of the sequencer state
  localparam logic [2:0] REGION_RST = 3'h0;
  localparam logic [7:0] LINE_RST = 8'h00;
  localparam logic [3:0] VOUT_RST = 4'h0;

  // Configuration registers loaded by the serial port
  typedef struct packed {
    logic [1:0] sweep_mode_select;
    logic [11:0] region3_sweep_count;
    logic [11:0] region0_sweep_count;
    logic [3:0][7:0] region_change_line;     // Index 0 is change line 1
    logic [3:0][2:0] pattern_repeat_count;   // Per transfer pattern
    logic [3:0][1:0] pattern_selector;       // Selector to pattern code
    logic [4:0][2:0] region_pattern_pointer; // Per region
  } vrs_cfg_s;

  // One vertical transfer pattern
  typedef struct packed {
    logic [8:0] group_length;      // Counter value that ends a group
    logic [3:0] start_level;       // Level of each output at group start
    logic [3:0][8:0] toggle_pos_1; // First toggle per output
    logic [3:0][8:0] toggle_pos_2; // Second toggle per output
  } vrs_pat_s;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_LOAD,
    ST_RUN
  } vrs_state_e;

endpackage
`default_nettype wire

// ### src/vrs_seq.sv
// Vertical region sequencer: picks the transfer pattern for each line.
// Assumes sync pins from outside the clock domain, configuration held
// steady by the serial port, and patterns loaded into the table.
`timescale 1ns/1ps
`default_nettype none

module vrs_seq (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Sync pins from the timing core
  input wire logic LINE_SYNC,
  input wire logic FRAME_SYNC,
  // Configuration registers
  input wire vrs_pkg::vrs_cfg_s CFG,
  // Pattern table write port
  input wire logic PAT_WE,
  input wire logic [1:0] PAT_ADDR,
  input wire vrs_pkg::vrs_pat_s PAT_WDATA,
  // Vertical transfer outputs
  output logic [3:0] VERT_OUT,
  // Status
  output logic [2:0] ACTIVE_REGION,
  output logic SWEEP_ACTIVE,
  output logic [7:0] LINE_COUNT,
  output logic GROUP_BUSY
);

  localparam int PAT_BITS = $bits(vrs_pkg::vrs_pat_s);

  // Region of a line: the last change line already passed
  function automatic logic [2:0] region_of(
    input logic [7:0] line,
    input vrs_pkg::vrs_cfg_s c
  );
    logic [2:0] r;
    r = vrs_pkg::REGION_RST;
    for (int n = 0; n < vrs_pkg::NUM_CHANGES; n++) begin
      if (line >= c.region_change_line[n]) begin
        r = 3'(n + 1);
      end
    end
    return r;
  endfunction

  // Selector chosen by a region pointer on an even or odd line
  function automatic logic [1:0] sel_of(
    input logic [2:0] ptr,
    input logic odd
  );
    logic [1:0] s;
    s = 2'h0;
    case (ptr)
      3'h0, 3'h1, 3'h2, 3'h3: s = ptr[1:0];
      vrs_pkg::PTR_ALT_LOW: s = {1'b0, odd};
      vrs_pkg::PTR_ALT_HIGH: s = {1'b1, odd};
      // Unused codes fall back to selector 0 rather than float
      default: s = 2'h0;
    endcase
    return s;
  endfunction

  // Sync pin synchronisers, first stage read only by the second
  logic ls_meta_reg, ls_sync_reg, ls_prev_reg;
  logic fs_meta_reg, fs_sync_reg, fs_prev_reg;
  logic line_start, frame_start;

  // Line and region bookkeeping
  logic [7:0] line_reg, line_next;
  logic [2:0] region_reg, region_new;
  logic sweep_reg, sweep_new;
  logic [1:0] sel_reg, sel_new;
  logic [1:0] pat_idx_reg, pat_new;
  logic [2:0] ptr_now;
  logic dec;

  // Group sequencing
  vrs_pkg::vrs_state_e state_reg;
  logic [8:0] vcnt_reg;
  logic [11:0] reps_left_reg, reps_new, sweep_cnt;
  logic group_end, wave_load;
  logic [PAT_BITS-1:0] pat_raw;
  vrs_pkg::vrs_pat_s pat_cur;

  // Two flops on each pin before any logic looks at it
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ls_meta_reg <= 1'b0;
      ls_sync_reg <= 1'b0;
      ls_prev_reg <= 1'b0;
      fs_meta_reg <= 1'b0;
      fs_sync_reg <= 1'b0;
      fs_prev_reg <= 1'b0;
    end else begin
      ls_meta_reg <= LINE_SYNC;
      ls_sync_reg <= ls_meta_reg;
      ls_prev_reg <= ls_sync_reg;
      fs_meta_reg <= FRAME_SYNC;
      fs_sync_reg <= fs_meta_reg;
      fs_prev_reg <= fs_sync_reg;
    end
  end

  // Rising edges mark the start of a line and of a frame
  assign line_start = ls_sync_reg & ~ls_prev_reg;
  assign frame_start = fs_sync_reg & ~fs_prev_reg;

  // Frame edge restarts the count; that line is line 0
  always_comb begin
    if (frame_start) begin
      line_next = vrs_pkg::LINE_RST;
    end else if (line_start) begin
      line_next = line_reg + 8'h01;
    end else begin
      line_next = line_reg;
    end
  end

  // Line counter
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      line_reg <= vrs_pkg::LINE_RST;
    end else begin
      line_reg <= line_next;
    end
  end

  // Decisions for the line now starting
  always_comb begin
    region_new = region_of(line_next, CFG);
    ptr_now = CFG.region_pattern_pointer[region_new];
    sel_new = sel_of(ptr_now, line_next[0]);
    pat_new = CFG.pattern_selector[sel_new];
    sweep_new =
      (region_new == vrs_pkg::SWEEP_REGION_A &&
       CFG.sweep_mode_select[vrs_pkg::SWEEP_BIT_R0]) ||
      (region_new == vrs_pkg::SWEEP_REGION_B &&
       CFG.sweep_mode_select[vrs_pkg::SWEEP_BIT_R3]);
    sweep_cnt = (region_new == vrs_pkg::SWEEP_REGION_A) ?
      CFG.region0_sweep_count : CFG.region3_sweep_count;
    if (sweep_cnt > vrs_pkg::SWEEP_MAX_REPEATS) begin
      sweep_cnt = vrs_pkg::SWEEP_MAX_REPEATS;
    end
    if (sweep_new) begin
      reps_new = sweep_cnt;
    end else begin
      reps_new = {9'h000, CFG.pattern_repeat_count[pat_new]};
    end
  end

  // sweep ignores line syncs in its region unless a frame edge comes with them
  assign dec = line_start &&
    !(sweep_reg && region_new == region_reg && !frame_start);

  // Region, sweep flag and pattern choice held for the line
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      region_reg <= vrs_pkg::REGION_RST;
      sweep_reg <= 1'b0;
      sel_reg <= 2'h0;
      pat_idx_reg <= 2'h0;
    end else if (dec) begin
      region_reg <= region_new;
      sweep_reg <= sweep_new;
      sel_reg <= sel_new;
      pat_idx_reg <= pat_new;
    end
  end

  // Pattern table, read one cycle behind the address
  vrs_pat_mem #(
    .WIDTH(PAT_BITS),
    .DEPTH(vrs_pkg::NUM_PATTERNS),
    .AW(2)
  ) u_mem (
    .clk(CLK),
    .rst(RST),
    .we(PAT_WE),
    .waddr(PAT_ADDR),
    .wdata(PAT_WDATA),
    .raddr(pat_idx_reg),
    .rdata(pat_raw)
  );

  assign pat_cur = vrs_pkg::vrs_pat_s'(pat_raw);

  // A group ends when the counter reaches the pattern length
  assign group_end = (state_reg == vrs_pkg::ST_RUN) &&
    (vcnt_reg == pat_cur.group_length);

  // Start levels load at the first group and at each later one
  assign wave_load = (state_reg == vrs_pkg::ST_LOAD &&
    reps_left_reg != 12'h000) || (group_end && reps_left_reg > 12'h001);

  // Sequencer: fetch pattern, load levels, run counted groups
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_reg <= vrs_pkg::ST_IDLE;
      vcnt_reg <= 9'h000;
      reps_left_reg <= 12'h000;
    end else if (dec) begin
      state_reg <= vrs_pkg::ST_FETCH;
      vcnt_reg <= 9'h000;
      reps_left_reg <= reps_new;
    end else begin
      unique case (state_reg)
        vrs_pkg::ST_IDLE: begin
          vcnt_reg <= 9'h000;
        end
        vrs_pkg::ST_FETCH: begin
          // Table read is in flight this cycle
          state_reg <= vrs_pkg::ST_LOAD;
        end
        vrs_pkg::ST_LOAD: begin
          state_reg <= (reps_left_reg == 12'h000) ?
            vrs_pkg::ST_IDLE : vrs_pkg::ST_RUN;
          vcnt_reg <= 9'h000;
        end
        vrs_pkg::ST_RUN: begin
          if (group_end) begin
            reps_left_reg <= reps_left_reg - 12'h001;
            vcnt_reg <= 9'h000;
            if (reps_left_reg == 12'h001) begin
              state_reg <= vrs_pkg::ST_IDLE;
            end
          end else begin
            vcnt_reg <= vcnt_reg + 9'h001;
          end
        end
      endcase
    end
  end

  // Waveform engine for the four vertical outputs
  vrs_wave u_wave (
    .clk(CLK),
    .rst(RST),
    .pat(pat_cur),
    .load(wave_load),
    .run(state_reg == vrs_pkg::ST_RUN && !group_end),
    .vcnt(vcnt_reg),
    .vout(VERT_OUT)
  );

  // Status outputs, all from registers
  assign ACTIVE_REGION = region_reg;
  assign SWEEP_ACTIVE = sweep_reg;
  assign LINE_COUNT = line_reg;
  assign GROUP_BUSY = (state_reg == vrs_pkg::ST_RUN);

  // Direct pointers pick their own selector
  a_sel_direct: assert property (
    @(posedge CLK) disable iff (RST)
    dec && ptr_now < vrs_pkg::PTR_ALT_LOW |=>
      sel_reg == $past(ptr_now[1:0]))
    else $error("direct pointer picked wrong selector");

  // High alternating pointer follows line parity
  a_sel_alternate: assert property (
    @(posedge CLK) disable iff (RST)
    dec && ptr_now == vrs_pkg::PTR_ALT_HIGH |=>
      sel_reg == {1'b1, line_reg[0]})
    else $error("alternating pointer ignored line parity");

  // Lines before the first change line are region 0
  a_region_first: assert property (
    @(posedge CLK) disable iff (RST)
    dec && line_next < CFG.region_change_line[0] |=>
      region_reg == 3'h0)
    else $error("early line not in region 0");

  // Sweep never runs outside regions 0 and 3
  a_sweep_region: assert property (
    @(posedge CLK) disable iff (RST)
    sweep_reg |-> region_reg == vrs_pkg::SWEEP_REGION_A ||
      region_reg == vrs_pkg::SWEEP_REGION_B)
    else $error("sweep active in a wrong region");

  // Sweep field of zero keeps normal timing
  a_sweep_off: assert property (
    @(posedge CLK) disable iff (RST)
    dec && CFG.sweep_mode_select == 2'h0 |=> !sweep_reg)
    else $error("sweep started with sweep field clear");

  // Normal lines restart the sequence on line sync
  a_line_restart: assert property (
    @(posedge CLK) disable iff (RST)
    line_start && !sweep_reg |=> state_reg == vrs_pkg::ST_FETCH)
    else $error("normal line did not restart");

  // Sweep carries across a line sync within its region
  a_sweep_span: assert property (
    @(posedge CLK) disable iff (RST)
    line_start && !frame_start && sweep_reg &&
      region_new == region_reg && state_reg == vrs_pkg::ST_RUN |=>
      state_reg != vrs_pkg::ST_FETCH)
    else $error("sweep broken by line sync");

  // Zero repeats leave the outputs idle after the fetch
  a_zero_reps: assert property (
    @(posedge CLK) disable iff (RST)
    dec && reps_new == 12'h000 ##1 !dec ##1 !dec |=>
      state_reg == vrs_pkg::ST_IDLE)
    else $error("groups ran with zero repeats");

  // Sweep repeats stay within the limit
  a_sweep_limit: assert property (
    @(posedge CLK) disable iff (RST)
    reps_left_reg <= vrs_pkg::SWEEP_MAX_REPEATS)
    else $error("sweep repeat count above limit");

endmodule
`default_nettype wire

// ### src/vrs_wave.sv
// Waveform engine: four vertical outputs from one transfer pattern.
// Assumes the caller loads start levels at each group start.
`timescale 1ns/1ps
`default_nettype none
module vrs_wave (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pattern and timing
  input wire vrs_pkg::vrs_pat_s pat,
  input wire logic load,
  input wire logic run,
  input wire logic [8:0] vcnt,
  // Vertical outputs
  output logic [3:0] vout
);

  // One toggle flop per vertical output
  for (genvar i = 0; i < vrs_pkg::NUM_VOUT; i++) begin : g_out
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        vout[i] <= vrs_pkg::VOUT_RST[i];
      end else if (load) begin
        vout[i] <= pat.start_level[i];
      end else if (run && (vcnt == pat.toggle_pos_1[i] ||
                           vcnt == pat.toggle_pos_2[i])) begin
        vout[i] <= ~vout[i];
      end
    end

    // First toggle position moves the output
    a_toggle_hit: assert property (
      @(posedge clk) disable iff (rst)
      run && !load && (vcnt == pat.toggle_pos_1[i]) |=>
        vout[i] != $past(vout[i]))
      else $error("output did not toggle at its position");

    // Group start shows the programmed levels
    a_start_level: assert property (
      @(posedge clk) disable iff (rst)
      load |=> vout[i] == $past(pat.start_level[i]))
      else $error("output missed its start level");
  end

endmodule
`default_nettype wire
